// ==== core/rgbl_i2c_slave.sv ====
// Purpose: Two-wire serial bus slave, byte level, for the LED block
// Assumes: Pins already synchronised by the caller
// Notes:   Emits write bytes with a first flag; fetches read bytes
`timescale 1ns/1ps
module rgbl_i2c_slave
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rstn,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_oe,
   output logic            o_wr_stb,
   output logic            o_wr_first,
   output logic [7:0]      o_wr_data,
   output logic            o_rd_stb,
   input  wire logic [7:0] i_rd_data
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK} rgbl_st_e;

   rgbl_st_e   st_reg, st_next;
   logic       scl_d_reg, sda_d_reg;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] cnt_reg, cnt_next;
   logic       rd_reg, rd_next;
   logic       first_reg, first_next;
   logic       oe_reg, oe_next;
   logic       wstb_reg, wstb_next;
   logic       rstb_reg, rstb_next;
   logic       scl_rise, scl_fall, start_c, stop_c;

   // Edge and bus condition detection
   assign scl_rise = i_scl & ~scl_d_reg;
   assign scl_fall = ~i_scl & scl_d_reg;
   assign start_c  = i_scl & scl_d_reg & sda_d_reg & ~i_sda;
   assign stop_c   = i_scl & scl_d_reg & ~sda_d_reg & i_sda;

   // Byte state machine; data sampled on rise, driven after fall
   always_comb
   begin
      st_next    = st_reg;
      sh_next    = sh_reg;
      cnt_next   = cnt_reg;
      rd_next    = rd_reg;
      first_next = first_reg & ~wstb_reg; // First flag lasts through one strobe
      oe_next    = oe_reg;
      wstb_next  = 1'b0;
      rstb_next  = 1'b0;
      if (start_c)
      begin
         st_next  = ST_ADDR;
         cnt_next = 4'h0;
         oe_next  = 1'b0;
      end
      else if (stop_c)
      begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end
      else
      begin
         case (st_reg)
            ST_IDLE: ;
            ST_ADDR, ST_WDATA:
            begin
               if (scl_rise && cnt_reg < 4'h8)
               begin
                  sh_next  = {sh_reg[6:0], i_sda};
                  cnt_next = cnt_reg + 4'h1;
               end
               else if (scl_fall && cnt_reg == 4'h8)
               begin
                  if (st_reg == ST_ADDR && sh_reg[7:1] != rgbl_pkg::DEV_ADDR)
                     st_next = ST_IDLE;
                  else
                  begin
                     oe_next = 1'b1;
                     st_next = ST_ACK;
                     if (st_reg == ST_ADDR)
                     begin
                        rd_next    = sh_reg[0];
                        first_next = 1'b1;
                     end
                     else
                     begin
                        wstb_next  = 1'b1;
                     end
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_next = 4'h0;
                  if (rd_reg)
                  begin
                     rstb_next = 1'b1;
                     st_next   = ST_RDATA;
                     oe_next   = 1'b0;
                  end
                  else
                  begin
                     oe_next = 1'b0;
                     st_next = ST_WDATA;
                  end
               end
            end
            ST_RDATA:
            begin
               // Load one cycle after fetch strobe; drive low for zero bits
               if (cnt_reg == 4'h0 && !rstb_reg && !scl_fall)
               begin
                  sh_next  = i_rd_data;
                  cnt_next = 4'h1;
                  oe_next  = ~i_rd_data[7];
               end
               else if (scl_fall && cnt_reg == 4'h8)
               begin
                  oe_next = 1'b0;
                  st_next = ST_RACK;
               end
               else if (scl_fall && cnt_reg != 4'h0)
               begin
                  sh_next  = {sh_reg[6:0], 1'b0};
                  oe_next  = ~sh_reg[6];
                  cnt_next = cnt_reg + 4'h1;
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
               begin
                  // Master NACK ends the read
                  if (i_sda)
                     st_next = ST_IDLE;
                  else
                     st_next = ST_ACK;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_reg    <= ST_IDLE;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         sh_reg    <= 8'h00;
         cnt_reg   <= 4'h0;
         rd_reg    <= 1'b0;
         first_reg <= 1'b0;
         oe_reg    <= 1'b0;
         wstb_reg  <= 1'b0;
         rstb_reg  <= 1'b0;
      end
      else
      begin
         st_reg    <= st_next;
         scl_d_reg <= i_scl;
         sda_d_reg <= i_sda;
         sh_reg    <= sh_next;
         cnt_reg   <= cnt_next;
         rd_reg    <= rd_next;
         first_reg <= first_next;
         oe_reg    <= oe_next;
         wstb_reg  <= wstb_next;
         rstb_reg  <= rstb_next;
      end
   end

   assign o_sda_oe   = oe_reg;
   assign o_wr_stb   = wstb_reg;
   assign o_wr_first = first_reg;
   assign o_wr_data  = sh_reg;
   assign o_rd_stb   = rstb_reg;
endmodule

// ==== core/rgbl_pkg.sv ====
// Purpose: Shared constants for the three-channel LED dimming block
// Assumes: 50 MHz system clock
// Notes:   Serial bus offsets, field positions and timing counts
package rgbl_pkg;
   // System clock
   localparam int unsigned CLK_HZ          = 50_000_000;
   // Serial bus device address, 7 bits
   localparam logic [6:0]  DEV_ADDR        = 7'h55;
   // Sub-address register selects (low seven bits)
   localparam logic [6:0]  SUB_DUTY0       = 7'h01;
   localparam logic [6:0]  SUB_DUTY1       = 7'h02;
   localparam logic [6:0]  SUB_DUTY2       = 7'h03;
   localparam logic [6:0]  SUB_CTRL        = 7'h04;
   // Sub-address field positions
   localparam int unsigned SUB_STEP_OFF_BIT = 7;
   // Output control fields
   localparam int unsigned CTRL_EN_BIT     = 1;
   localparam int unsigned CTRL_PDN_BIT    = 0;
   // Readback first byte fields
   localparam int unsigned RD_EN_BIT       = 5;
   localparam int unsigned RD_PDN_BIT      = 4;
   // Reset values
   localparam logic [7:0]  DUTY_RST        = 8'h00;
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   // PWM: 15 slots per period, about 3 kHz
   localparam logic [3:0]  PWM_SLOTS       = 4'hF;
   localparam int unsigned PWM_HZ          = 3_000;
   localparam int unsigned SLOT_CYC        = CLK_HZ / (PWM_HZ * 15);
   // Wake delay after power-down release, longest time, rounds down
   localparam int unsigned WAKE_MS         = 5;
   localparam int unsigned WAKE_CYC        = (CLK_HZ / 1000) * WAKE_MS;
endpackage

// ==== core/rgbl_top.sv ====
// Purpose: Three-channel LED PWM dimmer with serial bus register access
// Assumes: Single 50 MHz clock; all pins are asynchronous to it
// Notes:   Pins pass two flops; power-down holds outputs off with a wake delay
`timescale 1ns/1ps

// Behaviour
// - Duty registers use low nibble N; on-time is N/15 of period.
// - Control byte: bit1 enable, bit0 active-low power-down, resets to zero.
// - Enable low forces all three outputs off.
// - Power-down bit low enters power saving; high lets outputs pulse.
// - Auto-increment writes step sub-address per byte; otherwise one byte per sub-address.
// - Read first byte: enable bit5, power-down bit4, channel 2 duty low nibble.
// - Read second byte: channel 1 duty high nibble, channel 0 low nibble.
// - Outputs resume within 5 ms of power-down release.
// - Device answers bus address 1010101; direction bit high means read.
// - Sub-address 1,2,3 select duties 0,1,2; 4 selects output control.
// - Sub-address bit 7 low enables auto-increment, high disables it.
// - Data reset pin low returns all registers to defaults.
module rgbl_top
#(
   parameter int unsigned WAKE_CYCLES = rgbl_pkg::WAKE_CYC
)
(
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda,
   output logic      o_sda_oe,
   input  wire logic i_power_down_n,
   input  wire logic i_data_reset_n,
   output logic      o_led_drive_0,
   output logic      o_led_drive_1,
   output logic      o_led_drive_2,
   output logic      o_awake
);
   // Pin synchronisers
   logic [1:0] scl_s_reg, sda_s_reg, pdn_s_reg, drst_s_reg;

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         scl_s_reg  <= 2'b11;
         sda_s_reg  <= 2'b11;
         pdn_s_reg  <= 2'b00;
         drst_s_reg <= 2'b00;
      end
      else
      begin
         scl_s_reg  <= {scl_s_reg[0], i_scl};
         sda_s_reg  <= {sda_s_reg[0], i_sda};
         pdn_s_reg  <= {pdn_s_reg[0], i_power_down_n};
         drst_s_reg <= {drst_s_reg[0], i_data_reset_n};
      end
   end

   // Bus slave
   logic       wr_stb, wr_first, rd_stb, sda_oe;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   rgbl_i2c_slave u_slave
   (
      .i_clk_sys  (i_clk_sys),
      .i_rstn     (i_rstn),
      .i_scl      (scl_s_reg[1]),
      .i_sda      (sda_s_reg[1]),
      .o_sda_oe   (sda_oe),
      .o_wr_stb   (wr_stb),
      .o_wr_first (wr_first),
      .o_wr_data  (wr_data),
      .o_rd_stb   (rd_stb),
      .i_rd_data  (rd_data)
   );

   // Register file and sub-address pointer
   logic [7:0] duty_level_led_drive_0_reg, duty_level_led_drive_0_next;
   logic [7:0] duty_level_led_drive_1_reg, duty_level_led_drive_1_next;
   logic [7:0] duty_level_led_drive_2_reg, duty_level_led_drive_2_next;
   logic [7:0] output_control_reg, output_control_next;
   logic [6:0] sub_reg, sub_next;
   logic       addr_step_disable_reg, addr_step_disable_next;
   logic       sub_valid_reg, sub_valid_next;
   logic       rd_second_reg, rd_second_next;
   logic [7:0] rd_data_reg, rd_data_next;

   always_comb
   begin
      duty_level_led_drive_0_next   = duty_level_led_drive_0_reg;
      duty_level_led_drive_1_next   = duty_level_led_drive_1_reg;
      duty_level_led_drive_2_next   = duty_level_led_drive_2_reg;
      output_control_next    = output_control_reg;
      sub_next               = sub_reg;
      addr_step_disable_next = addr_step_disable_reg;
      sub_valid_next         = sub_valid_reg;
      rd_second_next         = rd_second_reg;
      rd_data_next           = rd_data_reg;
      if (!drst_s_reg[1])
      begin
         duty_level_led_drive_0_next = rgbl_pkg::DUTY_RST;
         duty_level_led_drive_1_next = rgbl_pkg::DUTY_RST;
         duty_level_led_drive_2_next = rgbl_pkg::DUTY_RST;
         output_control_next  = rgbl_pkg::CTRL_RST;
         sub_valid_next       = 1'b0;
      end
      else if (wr_stb)
      begin
         if (wr_first || !sub_valid_reg)
         begin
            sub_next               = wr_data[6:0];
            addr_step_disable_next = wr_data[rgbl_pkg::SUB_STEP_OFF_BIT];
            sub_valid_next         = 1'b1;
         end
         else
         begin
            case (sub_reg)
               rgbl_pkg::SUB_DUTY0: duty_level_led_drive_0_next = wr_data;
               rgbl_pkg::SUB_DUTY1: duty_level_led_drive_1_next = wr_data;
               rgbl_pkg::SUB_DUTY2: duty_level_led_drive_2_next = wr_data;
               rgbl_pkg::SUB_CTRL:  output_control_next  = wr_data;
               default: ;
            endcase
            // step, or expect a fresh sub-address next
            if (addr_step_disable_reg)
               sub_valid_next = 1'b0;
            else
               sub_next = sub_reg + 7'h01;
         end
      end
      // Sub-address must be re-sent at each new write start
      if (wr_stb && wr_first && drst_s_reg[1])
         sub_valid_next = 1'b1;
      if (rd_stb)
      begin
         rd_second_next = ~rd_second_reg;
         if (!rd_second_reg)
            rd_data_next = {2'b00,
                            output_control_reg[rgbl_pkg::CTRL_EN_BIT],
                            output_control_reg[rgbl_pkg::CTRL_PDN_BIT],
                            duty_level_led_drive_2_reg[3:0]};
         else
            rd_data_next = {duty_level_led_drive_1_reg[3:0], duty_level_led_drive_0_reg[3:0]};
      end
      if (wr_stb && wr_first)
         rd_second_next = 1'b0;
      if (sda_oe == 1'b0 && !rd_stb && wr_first && wr_stb)
         rd_second_next = 1'b0;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         duty_level_led_drive_0_reg   <= rgbl_pkg::DUTY_RST;
         duty_level_led_drive_1_reg   <= rgbl_pkg::DUTY_RST;
         duty_level_led_drive_2_reg   <= rgbl_pkg::DUTY_RST;
         output_control_reg    <= rgbl_pkg::CTRL_RST;
         sub_reg               <= 7'h00;
         addr_step_disable_reg <= 1'b0;
         sub_valid_reg         <= 1'b0;
         rd_second_reg         <= 1'b0;
         rd_data_reg           <= 8'h00;
      end
      else
      begin
         duty_level_led_drive_0_reg   <= duty_level_led_drive_0_next;
         duty_level_led_drive_1_reg   <= duty_level_led_drive_1_next;
         duty_level_led_drive_2_reg   <= duty_level_led_drive_2_next;
         output_control_reg    <= output_control_next;
         sub_reg               <= sub_next;
         addr_step_disable_reg <= addr_step_disable_next;
         sub_valid_reg         <= sub_valid_next;
         rd_second_reg         <= rd_second_next;
         rd_data_reg           <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

   // Power state: pin and register bit both must be high
   logic        run_req;
   logic [31:0] wake_cnt_reg, wake_cnt_next;
   logic        awake_reg, awake_next;

   assign run_req = pdn_s_reg[1] & output_control_reg[rgbl_pkg::CTRL_PDN_BIT];

   // power saving; wake within 5 ms
   always_comb
   begin
      wake_cnt_next = wake_cnt_reg;
      awake_next    = awake_reg;
      if (!run_req)
      begin
         wake_cnt_next = 32'h0000_0000;
         awake_next    = 1'b0;
      end
      else if (!awake_reg)
      begin
         if (wake_cnt_reg >= WAKE_CYCLES - 1)
            awake_next = 1'b1;
         else
            wake_cnt_next = wake_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wake_cnt_reg <= 32'h0000_0000;
         awake_reg    <= 1'b0;
      end
      else
      begin
         wake_cnt_reg <= wake_cnt_next;
         awake_reg    <= awake_next;
      end
   end

   // shared slot counter; stopped while asleep to save power
   logic [15:0] pre_reg, pre_next;
   logic [3:0]  slot_reg, slot_next;

   always_comb
   begin
      pre_next  = pre_reg;
      slot_next = slot_reg;
      if (!awake_reg)
      begin
         pre_next  = 16'h0000;
         slot_next = 4'h0;
      end
      else if (pre_reg == 16'(rgbl_pkg::SLOT_CYC - 1))
      begin
         pre_next  = 16'h0000;
         slot_next = (slot_reg == rgbl_pkg::PWM_SLOTS - 4'h1) ? 4'h0 : slot_reg + 4'h1;
      end
      else
         pre_next = pre_reg + 16'h0001;
   end

   // compare slot to duty nibble; enable gates outputs
   logic       en;
   logic [2:0] drv_next;
   logic [2:0] drv_reg;
   assign en = awake_reg & output_control_reg[rgbl_pkg::CTRL_EN_BIT];

   always_comb
   begin
      drv_next[0] = en & (slot_reg < duty_level_led_drive_0_reg[3:0]);
      drv_next[1] = en & (slot_reg < duty_level_led_drive_1_reg[3:0]);
      drv_next[2] = en & (slot_reg < duty_level_led_drive_2_reg[3:0]);
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pre_reg  <= 16'h0000;
         slot_reg <= 4'h0;
         drv_reg  <= 3'b000;
      end
      else
      begin
         pre_reg  <= pre_next;
         slot_reg <= slot_next;
         drv_reg  <= drv_next;
      end
   end

   // Outputs straight from flops; serial data is open drain, drives low only
   assign o_led_drive_0 = drv_reg[0];
   assign o_led_drive_1 = drv_reg[1];
   assign o_led_drive_2 = drv_reg[2];
   assign o_awake       = awake_reg;
   assign o_sda         = 1'b0;
   assign o_sda_oe      = sda_oe;
endmodule

// ==== dv/rgbl_bus_master.sv ====
// Purpose: Two-wire bus master model for the LED block
// Assumes: Open-drain data line with a pull-up
// Notes:   Data moves a few clocks after SCL falls, clear of START
`timescale 1ns/1ps
module rgbl_bus_master
(
   input  wire logic i_clk_sys,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   int half = 16; // Clocks per SCL half; raised for a slow bus
   // Bus idle: both lines released
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic start_cond();
      o_sda_low = 1'b1;
      tick(half);
      o_scl = 1'b0;
      tick(4);
   endtask
   task automatic stop_cond();
      o_sda_low = 1'b1;
      tick(half);
      o_scl = 1'b1;
      tick(half);
      o_sda_low = 1'b0;
      tick(half);
   endtask
   // Set while SCL low, sampled at the end of SCL high
   task automatic bit_xfer(input logic b, output logic s);
      o_sda_low = !b;
      tick(half);
      o_scl = 1'b1;
      tick(half);
      s = i_sda;
      o_scl = 1'b0;
      tick(4);
   endtask
   // byte MSB first then ninth bit
   task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                            output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_xfer(tx[i], rx[i]);
      bit_xfer(ack_in, ack_out);
   endtask
endmodule

// ==== dv/rgbl_checker.sv ====
// Purpose: Port assertions for the LED dimming block
// Assumes: One clock; sees only the top ports
// Notes:   Pin lag is two sync flops plus output flops
`timescale 1ns/1ps
module rgbl_checker
#(
   parameter int unsigned WAKE_CYCLES = 20
)
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic i_power_down_n,
   input wire logic i_data_reset_n,
   input wire logic o_led_drive_0,
   input wire logic o_led_drive_1,
   input wire logic o_led_drive_2,
   input wire logic o_awake
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   logic [31:0] hi_cnt_reg;
   logic [31:0] hi_cnt_next;
   logic        dark;
   // Cycles the power pin stayed high; saturates so it never wraps
   always_comb
   begin
      hi_cnt_next = 32'h0000_0000;
      if (i_power_down_n)
         hi_cnt_next = (&hi_cnt_reg) ? hi_cnt_reg : hi_cnt_reg + 32'h0000_0001;
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         hi_cnt_reg <= 32'h0000_0000;
      else
         hi_cnt_reg <= hi_cnt_next;
   end
   // All three outputs off
   assign dark = !o_led_drive_0 && !o_led_drive_1 && !o_led_drive_2;
   sequence s_pin_asleep;
      !i_power_down_n [*6];
   endsequence
   sequence s_scl_high;
      i_scl [*5];
   endsequence
   sda_low_a: assert property (o_sda == 1'b0)
      else $error("data pin driven high");
   sleep_pin_a: assert property (s_pin_asleep |-> !o_awake && dark)
      else $error("awake while power pin low");
   dark_asleep_a: assert property (!o_awake [*3] |-> dark)
      else $error("output on while asleep");
   led_awake_a: assert property ($rose(o_led_drive_0) || $rose(o_led_drive_1)
      || $rose(o_led_drive_2) |-> o_awake || $past(o_awake))
      else $error("output rose while asleep");
   wake_delay_a: assert property ($rose(o_awake) |-> hi_cnt_reg >= WAKE_CYCLES)
      else $error("woke before the wake delay");
   reset_dark_a: assert property (!i_data_reset_n [*6] |-> dark && !o_awake)
      else $error("settings kept under data reset");
   oe_steady_a: assert property (s_scl_high |-> $stable(o_sda_oe))
      else $error("data changed while clock high");
   oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
      else $error("data pulled while clock high");
endmodule
bind rgbl_top rgbl_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
   .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_power_down_n(i_power_down_n), .i_data_reset_n(i_data_reset_n),
   .o_led_drive_0(o_led_drive_0), .o_led_drive_1(o_led_drive_1),
   .o_led_drive_2(o_led_drive_2), .o_awake(o_awake));

// ==== dv/rgbl_tb_top.sv ====
// Purpose: Self-checking bench for the LED dimming block
// Assumes: Bus model on the serial pins; short wake count
// Notes:   Duty judged by on-time over one whole period
`timescale 1ns/1ps
module rgbl_tb_top;
   localparam int WAKE = 200;
   localparam int SLOT = rgbl_pkg::SLOT_CYC;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic       pdn_pin = 1'b1;
   logic       drst_n = 1'b1;
   logic       scl;
   logic       sda_low;
   logic       sda;
   logic       sda_out;
   logic       sda_oe;
   logic [2:0] led;
   logic       awake;
   int         err_total = 0;
   int         comparisons = 0;
   always #10 clk_sys = ~clk_sys;
   // Open-drain wire: low if either side pulls, else pull-up
   assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   rgbl_top #(.WAKE_CYCLES(WAKE)) dut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_scl(scl),
      .i_sda(sda), .o_sda(sda_out), .o_sda_oe(sda_oe), .i_power_down_n(pdn_pin),
      .i_data_reset_n(drst_n), .o_led_drive_0(led[0]), .o_led_drive_1(led[1]),
      .o_led_drive_2(led[2]), .o_awake(awake));
   rgbl_bus_master u_bm (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Addressed write of a byte list; every byte must be acked
   task automatic bus_write(input logic [7:0] q[$]);
      logic [7:0] rx;
      logic       ack;
      u_bm.start_cond();
      u_bm.xfer_byte({rgbl_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, ack);
      check("write address ack", ack, 1'b0);
      foreach (q[i])
      begin
         u_bm.xfer_byte(q[i], 1'b1, rx, ack);
         check("data ack", ack, 1'b0);
      end
      u_bm.stop_cond();
   endtask
   // Two-byte readback, master NACKs the last byte
   task automatic expect_regs(input logic [7:0] e1, input logic [7:0] e2);
      logic [7:0] b1;
      logic [7:0] b2;
      logic       ack;
      u_bm.start_cond();
      u_bm.xfer_byte({rgbl_pkg::DEV_ADDR, 1'b1}, 1'b1, b1, ack);
      check("read address ack", ack, 1'b0);
      u_bm.xfer_byte(8'hFF, 1'b0, b1, ack);
      u_bm.xfer_byte(8'hFF, 1'b1, b2, ack);
      u_bm.stop_cond();
      check("first byte", b1 & 8'h3F, e1);
      check("second byte", b2, e2);
   endtask
   task automatic t_reset_vals();
      expect_regs(8'h00, 8'h00);
      check("asleep after reset", awake, 1'b0);
      $display("reset values test done");
   endtask
   // Upper duty bits written but must not show
   task automatic t_auto_inc();
      bus_write('{8'h01, 8'hFA, 8'hF5, 8'h03, 8'h03});
      expect_regs(8'h33, 8'h5A);
      $display("auto-increment test done");
   endtask
   // Slow bus; a stepping pointer would corrupt duty 1
   task automatic t_single();
      u_bm.half = 40;
      bus_write('{8'h81, 8'h07, 8'h83, 8'h0C, 8'h85, 8'h0F});
      u_bm.half = 16;
      expect_regs(8'h3C, 8'h57);
      $display("single-step test done");
   endtask
   task automatic t_wrong_addr();
      logic [7:0] rx;
      logic       ack;
      u_bm.start_cond();
      u_bm.xfer_byte(8'hA8, 1'b1, rx, ack);
      check("foreign address nack", ack, 1'b1);
      u_bm.xfer_byte(8'h81, 1'b1, rx, ack);
      u_bm.xfer_byte(8'h0E, 1'b1, rx, ack);
      u_bm.stop_cond();
      expect_regs(8'h3C, 8'h57);
      $display("foreign address test done");
   endtask
   // Boundary duties 0 and 15 plus a middle one
   task automatic t_pwm();
      int n0 = 0;
      int n1 = 0;
      int n2 = 0;
      bus_write('{8'h01, 8'h00, 8'h0F, 8'h07});
      repeat (15 * SLOT)
      begin
         tick(1);
         n0 += led[0];
         n1 += led[1];
         n2 += led[2];
      end
      check("duty 0 on-time", n0, 0);
      check("duty 15 on-time", n1, 15 * SLOT);
      check("duty 7 on-time", n2, 7 * SLOT);
      $display("duty test done");
   endtask
   task automatic t_enable_pdn();
      int on = 0;
      int k;
      bus_write('{8'h84, 8'h01});
      repeat (2 * SLOT)
      begin
         tick(1);
         on += |led;
      end
      check("dark with enable low", on, 0);
      check("awake with enable low", awake, 1'b1);
      bus_write('{8'h84, 8'h02});
      check("asleep by control bit", awake, 1'b0);
      bus_write('{8'h84, 8'h03});
      check("still waking", awake, 1'b0);
      for (k = 0; k < WAKE + 40 && awake !== 1'b1; k++)
         tick(1);
      check("awake after delay", awake, 1'b1);
      tick(4);
      check("full duty on", led[1], 1'b1);
      $display("enable and power test done");
   endtask
   task automatic t_pins();
      pdn_pin = 1'b0;
      tick(8);
      check("asleep by pin", awake, 1'b0);
      check("dark by pin", led[1], 1'b0);
      pdn_pin = 1'b1;
      tick(WAKE - 10);
      check("pin wake early", awake, 1'b0);
      tick(60);
      check("pin wake done", awake, 1'b1);
      drst_n = 1'b0;
      tick(8);
      drst_n = 1'b1;
      tick(4);
      expect_regs(8'h00, 8'h00);
      check("asleep after data reset", awake, 1'b0);
      $display("pin test done");
   endtask
   // Main sequence: reset held 8 cycles, then each test
   initial
   begin
      tick(8);
      rstn = 1'b1;
      tick(4);
      t_reset_vals();
      t_auto_inc();
      t_single();
      t_wrong_addr();
      t_pwm();
      t_enable_pdn();
      t_pins();
      results();
   end
   // Watchdog; the tests need about two fifths of this span
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      err_total++;
      $display("watchdog expired");
      results();
   end
endmodule
